// [design/pth_trigger_seq.sv]
// Trigger handshake sequencer of a board-test prober: drives the go line to an
// external instrument while the tip is down, then advances or flags a timeout.
// Assumes synchronous inputs except doneIn, and an Avalon-MM master on the bus.
// Functional notes
// - Go is asserted toward the instrument once the tip has landed on the pin.
// - With active-high go polarity, go idles low and is high from tip-down until the step ends.
// - With active-low go polarity, go idles high and is low from tip-down until the step ends.
// - A programmable hold time in milliseconds sets how long go stays asserted; with completion on, go stays up until completion or the wait limit ends.
// - With the completion input off, the prober advances as soon as the hold time ends.
// - The completion input, its polarity and limit count only when enabled.
// - With active-high completion polarity, low is idle and high is the activation.
// - With active-low completion polarity, high is idle and low is the activation.
// - A programmable wait limit in milliseconds bounds the watch on the completion input.
// - With completion enabled, the input is watched in the window opened by go.
// - A completion activation within the window makes the prober lift and advance.
// - If the wait limit ends with no activation, an error is raised instead of advancing.
//
// Added by the designer: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
module pth_trigger_seq
    import pth_pkg::*;
#(
    parameter int unsigned TICK = TICK_CYCLES
)
(
    input  wire logic                    clk,
    input  wire logic                    rst_b,
    input  wire pth_pkg::pth_bus_req_t   avsReq,
    output logic [31:0]                  avsReadData,
    output logic                         avsWaitRequest,
    input  wire logic                    tipDown,
    input  wire logic                    doneIn,
    output logic                         goOut,
    output logic                         advance,
    output logic                         stepError,
    output logic                         irq
);
    import pth_pkg::*;

    localparam int unsigned TICK_W = $clog2(TICK + 1);

    // Refused at elaboration: a zero tick would never end a millisecond
    if (TICK < 1)
    begin
        $error("TICK must be at least one cycle");
    end

    logic                rstSync1Q;
    logic                rstSyncQ;
    logic                doneMetaQ;
    logic                doneSyncQ;
    pth_ctrl_t           ctrlQ;
    logic [TIME_W-1:0]   holdQ;
    logic [TIME_W-1:0]   waitQ;
    logic [EV_W-1:0]     irqStatQ;
    logic [EV_W-1:0]     irqEnQ;
    pth_state_t          stateQ;
    pth_state_t          stateD;
    logic [TICK_W-1:0]   tickCntQ;
    logic [TIME_W-1:0]   msCntQ;
    logic                busyQ;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rstSync1Q <= 1'b0;
            rstSyncQ  <= 1'b0;
        end
        else
        begin
            rstSync1Q <= 1'b1;
            rstSyncQ  <= rstSync1Q;
        end
    end

    // Second stage alone feeds the level decode
    always_ff @(posedge clk or negedge rstSyncQ)
    begin
        if (!rstSyncQ)
        begin
            doneMetaQ <= 1'b0;
            doneSyncQ <= 1'b0;
        end
        else
        begin
            doneMetaQ <= doneIn;
            doneSyncQ <= doneMetaQ;
        end
    end

    // Bus decode; one wait cycle makes read data come from a register
    wire       busReq    = avsReq.read | avsReq.write;
    wire       accept    = busReq & avsWaitRequest == 1'b0;
    wire [3:0] regIdx    = avsReq.address[5:2];
    wire       wrStrobe  = accept & avsReq.write;
    wire       wrCtrl    = wrStrobe & (regIdx == OFS_CTRL);
    wire       wrHold    = wrStrobe & (regIdx == OFS_HOLD);
    wire       wrWait    = wrStrobe & (regIdx == OFS_WAIT);
    wire       wrIrqEn   = wrStrobe & (regIdx == OFS_IRQ_EN);
    wire       wrIrqClr  = wrStrobe & (regIdx == OFS_IRQ_CLR);
    wire       wrAbort   = wrStrobe & (regIdx == OFS_CMD) & avsReq.writedata[0];

    // Activation level per selected polarity, ignored unless enabled
    wire doneActive = ctrlQ.doneEn & (doneSyncQ == ctrlQ.doneHigh);
    wire msTick     = (tickCntQ == TICK_W'(TICK - 1));
    wire msEnd      = msTick & (msCntQ == TIME_W'(0));
    wire inHold     = (stateQ == ST_HOLD);
    wire inWait     = (stateQ == ST_WAIT);
    wire holdDone   = inHold & msEnd & ~ctrlQ.doneEn;
    wire gotDone    = (inHold | inWait) & doneActive;
    wire timedOut   = inWait & msEnd & ~doneActive;
    wire stepEnd    = holdDone | gotDone | timedOut | wrAbort;

    logic [EV_W-1:0] evSet;
    assign evSet = {stateQ == ST_IDLE && tipDown, timedOut, holdDone | gotDone};

    always_comb
    begin
        stateD = stateQ;
        case (stateQ)
            ST_IDLE: if (tipDown) stateD = ST_HOLD;
            ST_HOLD:
            begin
                if (stepEnd)
                    stateD = ST_END;
                else if (msEnd)
                    stateD = ST_WAIT;
            end
            ST_WAIT: if (stepEnd) stateD = ST_END;
            ST_END:  if (!tipDown) stateD = ST_IDLE;
            default: stateD = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rstSyncQ)
    begin
        if (!rstSyncQ)
        begin
            stateQ   <= ST_IDLE;
            tickCntQ <= '0;
            msCntQ   <= '0;
        end
        else
        begin
            stateQ   <= stateD;
            tickCntQ <= (stateD != stateQ || msTick) ? '0 : tickCntQ + TICK_W'(1);
            if (stateQ == ST_IDLE)
                msCntQ <= holdQ - TIME_W'(1);
            else if (stateQ == ST_HOLD && msEnd)
                msCntQ <= waitQ - TIME_W'(1);
            else if (msTick && msCntQ != TIME_W'(0))
                msCntQ <= msCntQ - TIME_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rstSyncQ)
    begin
        if (!rstSyncQ)
        begin
            goOut     <= ~CTRL_RESET[CTRL_GO_HIGH];
            advance   <= 1'b0;
            stepError <= 1'b0;
            busyQ     <= 1'b0;
        end
        else
        begin
            // Assert in hold and wait only; drops as the step ends
            goOut     <= ((stateD == ST_HOLD) | (stateD == ST_WAIT)) ~^ ctrlQ.goHigh;
            advance   <= holdDone | gotDone;
            stepError <= timedOut;
            busyQ     <= stateD != ST_IDLE;
        end
    end

    always_ff @(posedge clk or negedge rstSyncQ)
    begin
        if (!rstSyncQ)
        begin
            ctrlQ    <= CTRL_RESET;
            holdQ    <= HOLD_RESET;
            waitQ    <= WAIT_RESET;
            irqEnQ   <= '0;
            irqStatQ <= '0;
            irq      <= 1'b0;
        end
        else
        begin
            if (wrCtrl)
                ctrlQ <= avsReq.writedata[2:0];
            if (wrHold)
                holdQ <= (avsReq.writedata[TIME_W-1:0] == '0) ? TIME_W'(1)
                                                              : avsReq.writedata[TIME_W-1:0];
            if (wrWait)
                waitQ <= (avsReq.writedata[TIME_W-1:0] == '0) ? TIME_W'(1)
                                                              : avsReq.writedata[TIME_W-1:0];
            if (wrIrqEn)
                irqEnQ <= avsReq.writedata[EV_W-1:0];
            // Set wins over a clear in the same cycle
            irqStatQ <= (irqStatQ & ~(wrIrqClr ? avsReq.writedata[EV_W-1:0] : '0)) | evSet;
            irq      <= |(((irqStatQ & ~(wrIrqClr ? avsReq.writedata[EV_W-1:0] : '0)) | evSet)
                          & (wrIrqEn ? avsReq.writedata[EV_W-1:0] : irqEnQ));
        end
    end

    logic [31:0] rdMux;
    always_comb
    begin
        case (regIdx)
            OFS_CTRL:     rdMux = {29'h0, ctrlQ};
            OFS_HOLD:     rdMux = {16'h0, holdQ};
            OFS_WAIT:     rdMux = {16'h0, waitQ};
            OFS_STATUS:   rdMux = {26'h0, busyQ, doneSyncQ, stepError, advance, stateQ};
            OFS_IRQ_STAT: rdMux = {29'h0, irqStatQ};
            OFS_IRQ_EN:   rdMux = {29'h0, irqEnQ};
            default:      rdMux = 32'h0;
        endcase
    end

    always_ff @(posedge clk or negedge rstSyncQ)
    begin
        if (!rstSyncQ)
        begin
            avsWaitRequest <= 1'b1;
            avsReadData    <= 32'h0;
        end
        else
        begin
            avsWaitRequest <= ~(busReq & avsWaitRequest);
            if (busReq & avsWaitRequest & avsReq.read)
                avsReadData <= rdMux;
        end
    end

    a_go_idle_level: assert property (@(posedge clk) disable iff (!rstSyncQ)
        $past(stateD) == ST_IDLE |-> goOut == ~ctrlQ.goHigh || $past(wrCtrl))
        else $error("go not idle while sequencer idle");
    a_go_active_lvl: assert property (@(posedge clk) disable iff (!rstSyncQ)
        (stateQ == ST_WAIT) && !$past(wrCtrl) |-> goOut == ctrlQ.goHigh)
        else $error("go not active in wait window");
    a_advance_cause: assert property (@(posedge clk) disable iff (!rstSyncQ)
        advance |-> $past(holdDone) || $past(gotDone))
        else $error("advance without cause");
    a_error_cause: assert property (@(posedge clk) disable iff (!rstSyncQ)
        stepError |-> $past(inWait) && !$past(doneActive))
        else $error("error without timeout");
    a_err_excl_adv: assert property (@(posedge clk) disable iff (!rstSyncQ)
        !(stepError && advance))
        else $error("error and advance together");
    a_done_ignored: assert property (@(posedge clk) disable iff (!rstSyncQ)
        !ctrlQ.doneEn && inHold && !msEnd && !wrAbort |=> stateQ == ST_HOLD)
        else $error("completion honoured while disabled");
    a_done_advance: assert property (@(posedge clk) disable iff (!rstSyncQ)
        gotDone |=> advance && stateQ == ST_END)
        else $error("completion did not advance");
    a_go_released: assert property (@(posedge clk) disable iff (!rstSyncQ)
        stateQ == ST_END && !$past(wrCtrl) |-> goOut == ~ctrlQ.goHigh)
        else $error("go not released at step end");
    a_sync_delay: assert property (@(posedge clk) disable iff (!rstSyncQ)
        $past(rstSyncQ, 2) |-> doneSyncQ == $past(doneIn, 2))
        else $error("completion sync depth wrong");
    c_hold_only:  cover property (@(posedge clk) disable iff (!rstSyncQ) holdDone);
    c_completion: cover property (@(posedge clk) disable iff (!rstSyncQ) gotDone && inWait);
    c_timeout:    cover property (@(posedge clk) disable iff (!rstSyncQ) timedOut);
endmodule

// [design/pth_pkg.sv]
// Package for the prober trigger handshake sequencer.
// Assumes a single 20 MHz system clock; shared by the sequencer and its bench.
package pth_pkg;

    localparam int unsigned CLK_HZ          = 20000000;
    localparam int unsigned MS_PER_S        = 1000;
    localparam int unsigned TICK_CYCLES     = CLK_HZ / MS_PER_S;
    localparam int unsigned TIME_W          = 16;

    // Register word indices, decoded from address bits 5:2 (byte offset is four times the index)
    localparam logic [3:0] OFS_CTRL     = 4'h0;
    localparam logic [3:0] OFS_HOLD     = 4'h1;
    localparam logic [3:0] OFS_WAIT     = 4'h2;
    localparam logic [3:0] OFS_STATUS   = 4'h3;
    localparam logic [3:0] OFS_IRQ_STAT = 4'h4;
    localparam logic [3:0] OFS_IRQ_EN   = 4'h5;
    localparam logic [3:0] OFS_IRQ_CLR  = 4'h6;
    localparam logic [3:0] OFS_CMD      = 4'h7;

    // Control bit positions
    localparam int unsigned CTRL_GO_HIGH   = 0;
    localparam int unsigned CTRL_DONE_EN   = 1;
    localparam int unsigned CTRL_DONE_HIGH = 2;
    localparam logic [2:0]  CTRL_RESET     = 3'h1;

    localparam logic [TIME_W-1:0] HOLD_RESET = 16'h0064;
    localparam logic [TIME_W-1:0] WAIT_RESET = 16'h0064;

    // Event bits: 0 advance, 1 timeout error, 2 step started
    localparam int unsigned EV_W       = 3;
    localparam int unsigned EV_ADVANCE = 0;
    localparam int unsigned EV_TIMEOUT = 1;
    localparam int unsigned EV_START   = 2;

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_HOLD = 2'b01,
        ST_WAIT = 2'b10,
        ST_END  = 2'b11
    } pth_state_t;

    typedef struct packed
    {
        logic [5:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
    } pth_bus_req_t;

    // Members run from the top bit down: go polarity must land on bit 0
    typedef struct packed
    {
        logic        doneHigh;
        logic        doneEn;
        logic        goHigh;
    } pth_ctrl_t;

endpackage

// [verification/pth_instr_model.sv]
// Instrument model on the far side of the go and completion lines.
// Assumes the bench sets polarities to match the sequencer control word.
`timescale 1ns/1ps
module pth_instr_model
(
    input  wire logic       clk,
    input  wire logic       goOut,
    input  wire logic       goHigh,
    input  wire logic       doneHigh,
    input  wire logic       respond,
    input  wire logic [7:0] dly,
    output logic            doneIn
);
    logic [7:0] cnt_q = 8'h00;
    wire        goSeen = (goOut === goHigh);

    // Measures only while go is asserted; replies after dly cycles
    always_ff @(posedge clk)
    begin
        cnt_q <= !goSeen ? 8'h00 : (cnt_q == 8'hff ? cnt_q : cnt_q + 8'h01);
    end
    // Completion held active until go drops, idle level otherwise
    assign doneIn = (respond && goSeen && cnt_q >= dly) ? doneHigh : !doneHigh;
endmodule

// [verification/pth_trigger_seq_test.sv]
// Self-checking bench for the trigger sequencer, millisecond tick scaled down.
// Assumes pth_instr_model answers on doneIn; registers reached over Avalon-MM.
`timescale 1ns/1ps
module pth_trigger_seq_test;
    import pth_pkg::*;
    localparam int TK   = 4;
    localparam int HOLD = 3;
    localparam int WT   = 2;
    localparam int TOT  = (HOLD + WT) * TK;
    logic         clk      = 1'b0;
    logic         rst_b    = 1'b0;
    pth_bus_req_t req      = '0;
    logic         tipDown  = 1'b0;
    logic         goHigh   = 1'b1;
    logic         doneHigh = 1'b0;
    logic         respond  = 1'b0;
    logic [7:0]   respDly  = 8'h01;
    logic [31:0]  rdData, rv;
    logic         waitReq, doneIn, goOut, advance, stepError, irq;
    int           err_total = 0, checks_done = 0, cyc = 0;

    pth_trigger_seq #(.TICK(TK)) i_dut (.clk(clk), .rst_b(rst_b), .avsReq(req),
        .avsReadData(rdData), .avsWaitRequest(waitReq), .tipDown(tipDown), .doneIn(doneIn),
        .goOut(goOut), .advance(advance), .stepError(stepError), .irq(irq));
    pth_instr_model i_instr (.clk(clk), .goOut(goOut), .goHigh(goHigh), .doneHigh(doneHigh),
        .respond(respond), .dly(respDly), .doneIn(doneIn));

    always #25 clk = ~clk;

    task print_verdict;
        $display("errors %0d checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // A hung handshake lands here
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            print_verdict();
        end
    end

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        checks_done++;
        if (got !== ex)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{address: a, read: !wr, write: wr, writedata: wd};
        do
        begin
            @(posedge clk);
            n++;
        end while (waitReq !== 1'b0 && n < 50);
        rv = rdData;
        req <= '0;
        chk("bus answer", 1, 32'(n < 50));
    endtask

    task automatic rdChk(input logic [3:0] ofs, input logic [31:0] ex, input string nm);
        bus(1'b0, {ofs, 2'b00}, 32'h0);
        chk(nm, ex, rv);
    endtask

    // Model: no completion -> hold end; reply -> reply delay plus sync; silence -> timeout
    task automatic step(input logic [2:0] ctrl, input logic resp);
        int n, kind, expCyc, expKind, d;
        d = $urandom_range(1, TOT - 8);
        goHigh <= ctrl[CTRL_GO_HIGH];
        doneHigh <= ctrl[CTRL_DONE_HIGH];
        respond <= resp;
        respDly <= 8'(d);
        bus(1'b1, {OFS_CTRL, 2'b00}, 32'(ctrl));
        expKind = (ctrl[CTRL_DONE_EN] && !resp) ? 1 : 0;
        expCyc = !ctrl[CTRL_DONE_EN] ? HOLD * TK : (resp ? d + 4 : TOT);
        // Go idle level follows a polarity write one edge later
        repeat (2) @(negedge clk);
        chk("goOut idle", !goHigh, goOut);
        @(posedge clk);
        tipDown <= 1'b1;
        n = 0;
        kind = -1;
        while (kind < 0 && n < 200)
        begin
            @(negedge clk);
            n++;
            if (advance === 1'b1) kind = 0;
            else if (stepError === 1'b1) kind = 1;
            else if (n > 2) chk("goOut active", goHigh, goOut);
        end
        chk("step outcome", 32'(expKind), 32'(kind));
        chk("step length", 1, 32'(n - expCyc <= 3 && expCyc - n <= 3));
        chk("goOut at end", !goHigh, goOut);
        @(posedge clk);
        tipDown <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    initial
    begin
        void'($urandom(32'h9151));
        repeat (2) @(posedge clk);
        chk("goOut in reset", 0, goOut);
        chk("waitrequest in reset", 1, waitReq);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        rdChk(OFS_CTRL, 32'(CTRL_RESET), "ctrl reset");
        rdChk(OFS_HOLD, 32'(HOLD_RESET), "hold reset");
        rdChk(OFS_WAIT, 32'(WAIT_RESET), "wait reset");
        rdChk(4'h8, 0, "unmapped read");
        bus(1'b1, {OFS_HOLD, 2'b00}, HOLD);
        bus(1'b1, {OFS_WAIT, 2'b00}, WT);
        bus(1'b1, {OFS_IRQ_EN, 2'b00}, 32'h7);
        for (int c = 0; c < 8; c++)
            for (int r = 0; r < 2; r++)
                step(3'(c), 1'(r));
        chk("irq enabled", 1, irq);
        rdChk(OFS_IRQ_STAT, 32'h7, "events seen");
        bus(1'b1, {OFS_IRQ_CLR, 2'b00}, 32'h7);
        rdChk(OFS_IRQ_STAT, 0, "events cleared");
        bus(1'b1, {OFS_IRQ_EN, 2'b00}, 32'h0);
        step(3'h1, 1'b0);
        chk("irq masked", 0, irq);
        rdChk(OFS_IRQ_STAT, (1 << EV_ADVANCE) | (1 << EV_START), "advance event");
        bus(1'b1, {OFS_IRQ_EN, 2'b00}, 32'(1 << EV_ADVANCE));
        repeat (2) @(negedge clk);
        chk("irq unmasked", 1, irq);
        bus(1'b1, {OFS_IRQ_CLR, 2'b00}, 32'(1 << EV_ADVANCE));
        repeat (2) @(negedge clk);
        chk("irq after clear", 0, irq);
        rdChk(OFS_IRQ_STAT, 32'(1 << EV_START), "start left");
        // Abort in mid-hold: go drops with neither pulse, status follows
        @(posedge clk);
        tipDown <= 1'b1;
        repeat (4) @(posedge clk);
        rdChk(OFS_STATUS, 32'h31, "status in hold"); // busy, done idle high, hold
        bus(1'b1, {OFS_CMD, 2'b00}, 32'h1);
        repeat (HOLD * TK)
        begin
            @(negedge clk);
            chk("goOut aborted", !goHigh, goOut);
            chk("no pulse on abort", 0, {advance, stepError});
        end
        rdChk(OFS_STATUS, 32'h33, "status ended");
        @(posedge clk);
        tipDown <= 1'b0;
        repeat (2) @(posedge clk);
        rdChk(OFS_STATUS, 32'h10, "status idle");
        print_verdict();
    end
endmodule
